// ### rtl/wdr_reset_ctrl.sv
// Watchdog timer and reset source sequencer with its two control registers
`timescale 1ns/1ps

// Behaviour
// - Bit 5 write enables comparator reset
// - Enabled comparator below reference resets, pin untouched
// - Bit 5 reads 1 after comparator reset
// - Bit 6 enables low-level convert-start reset
// - Bit 6 reads 1 after convert-start reset
// - 21-bit watchdog count resets on limit
// - Every reset restarts watchdog, interval all ones
// - Byte A5 enables watchdog, clears count
// - DE then AD within 4 cycles disables
// - Byte FF locks out disable until reset
// - Timeout is four to three plus interval
// - Interval written only when top bit zero
// - Watchdog read returns interval in low bits
// - Watchdog read bit 4 shows activity
// - Bit 3 flags watchdog timeout reset
// - Bit 4 forces internal software reset
// - Bit 1 forces power-on reset, pin low
// - Bits 7,2,0 flag test, clock, pin resets
// - Hold 12 cycles after pin release
module wdr_reset_ctrl #(
  parameter int unsigned POR_HOLD_CYCLES = wdr_pkg::POR_HOLD_CYCLES_DEF
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       comparator_below,
  input  wire logic       convert_start_input,
  input  wire logic       missing_clock_detect,
  input  wire logic       test_port_reset_cmd,
  input  wire logic       rst_pin_in,
  output logic            rst_pin_out,
  output logic            rst_pin_oe,
  output logic            system_reset,
  output logic            watchdog_active
);

  // Watchdog limit: 4^(3+iv) = 2^(6+2*iv) system clock periods
  function automatic logic [wdr_pkg::WD_CNT_W-1:0] wdr_limit(input logic [2:0] iv);
    logic [wdr_pkg::WD_CNT_W-1:0] one;
    one = {{(wdr_pkg::WD_CNT_W-1){1'b0}}, 1'b1};
    wdr_limit = one << (2 * (wdr_pkg::WD_EXP_BASE + 32'(iv)));
  endfunction

  // Lowest set bit wins, giving a one-hot cause
  function automatic logic [7:0] wdr_pick(input logic [7:0] req);
    logic [7:0] seen;
    wdr_pick = 8'h00;
    seen     = 8'h00;
    for (int i = 0; i < wdr_pkg::RC_NUM_SRC; i++)
    begin
      if (i > 0)
        seen[i] = seen[i-1] | req[i-1];
      wdr_pick[i] = req[i] & ~seen[i];
    end
  endfunction

  wdr_pkg::wdr_state_t               state;
  wdr_pkg::wdr_state_t               next_state;
  logic [wdr_pkg::HOLD_W-1:0]        hold_cnt;
  logic [7:0]                        cause;
  logic                              cmp_enable;
  logic                              cnv_enable;
  logic                              wd_enable;
  logic                              wd_lock;
  logic                              dis_pending;
  logic [2:0]                        dis_cnt;
  logic [2:0]                        wd_iv;
  logic [wdr_pkg::WD_CNT_W-1:0]      wd_cnt;
  logic [7:0]                        req;
  logic [7:0]                        pick;
  logic                              rc_wr;
  logic                              wd_wr;
  logic                              wd_expire;
  logic                              entering;
  logic                              src_active;
  logic                              hold_done;
  logic                              por_done;

  // Register strobes decode
  assign rc_wr = reg_wr && (reg_addr == wdr_pkg::RC_ADDR);
  assign wd_wr = reg_wr && (reg_addr == wdr_pkg::WD_ADDR);

  // Watchdog reaches its limit while enabled
  // A shorter interval written past the count expires at once instead of wrapping
  assign wd_expire = wd_enable &&
                     (wd_cnt >= wdr_limit(wd_iv) - 1'b1);

  // Reset requests gathered while running
  always_comb
  begin
    req = 8'h00;
    req[wdr_pkg::RC_PIN_BIT]  = ~rst_pin_in & ~rst_pin_oe;
    req[wdr_pkg::RC_POR_BIT]  = rc_wr & reg_wdata[wdr_pkg::RC_POR_BIT];
    req[wdr_pkg::RC_MCD_BIT]  = missing_clock_detect;
    req[wdr_pkg::RC_WD_BIT]   = wd_expire;
    req[wdr_pkg::RC_SW_BIT]   = rc_wr & reg_wdata[wdr_pkg::RC_SW_BIT];
    req[wdr_pkg::RC_CMP_BIT]  = cmp_enable & comparator_below;
    req[wdr_pkg::RC_CNV_BIT]  = cnv_enable & ~convert_start_input;
    req[wdr_pkg::RC_TEST_BIT] = test_port_reset_cmd;
  end

  assign pick     = wdr_pick(req);
  assign entering = (state == wdr_pkg::WDR_ST_RUN) && (req != 8'h00);

  // Level sources keep the hold going while they stay active
  always_comb
  begin
    src_active = 1'b0;
    if (cause[wdr_pkg::RC_PIN_BIT])
      src_active = ~rst_pin_in;
    if (cause[wdr_pkg::RC_MCD_BIT])
      src_active = missing_clock_detect;
    if (cause[wdr_pkg::RC_CMP_BIT])
      src_active = comparator_below;
    if (cause[wdr_pkg::RC_CNV_BIT])
      src_active = ~convert_start_input;
    if (cause[wdr_pkg::RC_TEST_BIT])
      src_active = test_port_reset_cmd;
  end

  assign hold_done = (hold_cnt == wdr_pkg::HOLD_W'(wdr_pkg::HOLD_CYCLES - 1)) && !src_active;
  assign por_done  = (hold_cnt == wdr_pkg::HOLD_W'(POR_HOLD_CYCLES - 1));

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      wdr_pkg::WDR_ST_RUN:
      begin
        if (entering)
          next_state = pick[wdr_pkg::RC_POR_BIT] ? wdr_pkg::WDR_ST_PIN_HOLD
                                                  : wdr_pkg::WDR_ST_HOLD;
      end
      wdr_pkg::WDR_ST_HOLD:
      begin
        if (hold_done)
          next_state = wdr_pkg::WDR_ST_RUN;
      end
      wdr_pkg::WDR_ST_PIN_HOLD:
      begin
        if (por_done)
          next_state = wdr_pkg::WDR_ST_HOLD;
      end
      default:
        next_state = wdr_pkg::WDR_ST_HOLD;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      state <= wdr_pkg::WDR_ST_HOLD;
    else if (clk_en)
      state <= next_state;
  end

  // Hold counter, restarted on each state change and while a source stays active
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      hold_cnt <= '0;
    else if (clk_en)
    begin
      if (next_state != state || state == wdr_pkg::WDR_ST_RUN)
        hold_cnt <= '0;
      else if (state == wdr_pkg::WDR_ST_HOLD && src_active)
        hold_cnt <= '0;
      else
        hold_cnt <= hold_cnt + 1'b1;  // Done in either hold state changes state
    end
  end

  // Cause flags: one-hot, replaced only on entry to a reset
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      cause <= wdr_pkg::RC_CAUSE_POR;
    else if (clk_en && entering)
      cause <= pick;
  end

  // Reset source enables, cleared by every reset
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      cmp_enable <= 1'b0;
      cnv_enable <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state != wdr_pkg::WDR_ST_RUN || entering)
      begin
        cmp_enable <= 1'b0;
        cnv_enable <= 1'b0;
      end
      else if (rc_wr)
      begin
        cmp_enable <= reg_wdata[wdr_pkg::RC_CMP_BIT];
        cnv_enable <= reg_wdata[wdr_pkg::RC_CNV_BIT];
      end
    end
  end

  // Watchdog counter
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      wd_cnt <= '0;
    else if (clk_en)
    begin
      if (state != wdr_pkg::WDR_ST_RUN || entering)
        wd_cnt <= '0;
      else if (wd_wr && reg_wdata == wdr_pkg::WD_CMD_RELOAD)
        wd_cnt <= '0;
      else if (wd_enable)
        wd_cnt <= wd_cnt + 1'b1;
    end
  end

  // Watchdog enable, lockout and interval
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      wd_enable <= 1'b1;
      wd_lock   <= 1'b0;
      wd_iv     <= wdr_pkg::WD_IV_RESET;
    end
    else if (clk_en)
    begin
      if (state != wdr_pkg::WDR_ST_RUN || entering)
      begin
        wd_enable <= 1'b1;
        wd_lock   <= 1'b0;
        wd_iv     <= wdr_pkg::WD_IV_RESET;
      end
      else if (wd_wr)
      begin
        if (reg_wdata == wdr_pkg::WD_CMD_RELOAD)
          wd_enable <= 1'b1;
        else if (reg_wdata == wdr_pkg::WD_CMD_DIS2 && dis_pending && !wd_lock)
          wd_enable <= 1'b0;
        else if (reg_wdata == wdr_pkg::WD_CMD_LOCK)
          wd_lock <= 1'b1;
        else if (!reg_wdata[wdr_pkg::WD_CFG_BIT])
          wd_iv <= reg_wdata[wdr_pkg::WD_IV_W-1:0];
      end
    end
  end

  // First half of the disable pair and its window counter
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      dis_pending <= 1'b0;
      dis_cnt     <= 3'h0;
    end
    else if (clk_en)
    begin
      if (state != wdr_pkg::WDR_ST_RUN || entering)
        dis_pending <= 1'b0;
      else if (wd_wr && reg_wdata == wdr_pkg::WD_CMD_DIS1)
      begin
        dis_pending <= 1'b1;
        dis_cnt     <= 3'h0;
      end
      else if (wd_wr && reg_wdata[wdr_pkg::WD_CFG_BIT])
        dis_pending <= 1'b0;
      else if (dis_pending)
      begin
        if (dis_cnt == wdr_pkg::DIS_WINDOW_CYCLES - 3'h1)
          dis_pending <= 1'b0;
        else
          dis_cnt <= dis_cnt + 3'h1;
      end
    end
  end

  // Read data, valid only in the cycle after the read strobe
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= wdr_pkg::RC_ZERO;
    else if (clk_en)
    begin
      reg_rdata <= wdr_pkg::RC_ZERO;
      if (reg_rd && reg_addr == wdr_pkg::RC_ADDR)
        reg_rdata <= cause;
      else if (reg_rd && reg_addr == wdr_pkg::WD_ADDR)
      begin
        reg_rdata[wdr_pkg::WD_IV_W-1:0]      <= wd_iv;
        reg_rdata[wdr_pkg::WD_STATUS_BIT]    <= wd_enable;
      end
    end
  end

  // Reset outputs; the pin is driven only while the reset input is high and for a forced power-on reset
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      system_reset <= 1'b1;
      rst_pin_oe   <= 1'b1;
      rst_pin_out  <= 1'b0;
    end
    else if (clk_en)
    begin
      system_reset <= (next_state != wdr_pkg::WDR_ST_RUN);
      rst_pin_oe   <= (next_state == wdr_pkg::WDR_ST_PIN_HOLD);
      rst_pin_out  <= 1'b0;
    end
  end

  // Watchdog status mirrored to a pin
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      watchdog_active <= 1'b1;
    else if (clk_en)
      watchdog_active <= (next_state != wdr_pkg::WDR_ST_RUN) || (wd_enable &&
                         !(wd_wr && reg_wdata == wdr_pkg::WD_CMD_DIS2 &&
                           dis_pending && !wd_lock)) ||
                         (wd_wr && reg_wdata == wdr_pkg::WD_CMD_RELOAD);
  end

endmodule

// ### rtl/wdr_pkg.sv
// Package with addresses, field positions, commands and timing for the watchdog and reset block
package wdr_pkg;

  // Register addresses on the byte-wide register port
  localparam logic [7:0] RC_ADDR = 8'hEF;  // reset_cause_and_force
  localparam logic [7:0] WD_ADDR = 8'hFE;  // watchdog_command

  // Bit positions in reset_cause_and_force
  localparam int unsigned RC_PIN_BIT  = 0;
  localparam int unsigned RC_POR_BIT  = 1;
  localparam int unsigned RC_MCD_BIT  = 2;
  localparam int unsigned RC_WD_BIT   = 3;
  localparam int unsigned RC_SW_BIT   = 4;
  localparam int unsigned RC_CMP_BIT  = 5;
  localparam int unsigned RC_CNV_BIT  = 6;
  localparam int unsigned RC_TEST_BIT = 7;
  localparam int unsigned RC_NUM_SRC  = 8;

  // Reset value of the cause flags after a supply reset
  localparam logic [7:0] RC_CAUSE_POR = 8'h02;
  localparam logic [7:0] RC_ZERO      = 8'h00;

  // Command bytes and fields of watchdog_command
  localparam logic [7:0] WD_CMD_RELOAD = 8'hA5;
  localparam logic [7:0] WD_CMD_DIS1   = 8'hDE;
  localparam logic [7:0] WD_CMD_DIS2   = 8'hAD;
  localparam logic [7:0] WD_CMD_LOCK   = 8'hFF;
  localparam int unsigned WD_CFG_BIT    = 7;
  localparam int unsigned WD_STATUS_BIT = 4;
  localparam int unsigned WD_IV_W       = 3;
  localparam logic [2:0] WD_IV_RESET   = 3'h7;
  localparam int unsigned WD_CNT_W      = 21;
  localparam int unsigned WD_EXP_BASE   = 3;

  // Disable window, in system clock cycles
  localparam logic [2:0] DIS_WINDOW_CYCLES = 3'h4;

  // Least hold after the external reset pin is released, in cycles
  localparam int unsigned HOLD_CYCLES = 12;

  // Clock and pin-driven power-on hold time
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned POR_HOLD_MS        = 100;
  localparam int unsigned NS_PER_MS          = 1000000;
  localparam int unsigned POR_HOLD_CYCLES_DEF = POR_HOLD_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned HOLD_W             = 24;

  // Reset sequencer states, Gray along run -> hold -> pin hold
  typedef enum logic [1:0] {
    WDR_ST_RUN      = 2'h0,
    WDR_ST_HOLD     = 2'h1,
    WDR_ST_PIN_HOLD = 2'h3
  } wdr_state_t;

endpackage

// ### testbench/wdr_reset_ctrl_properties.sv
// Port-level assertions for the watchdog and reset block
`timescale 1ns/1ps
module wdr_reset_ctrl_checker #(
  parameter int unsigned POR_HOLD_CYCLES = 20
) (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       rst_pin_in,
  input wire logic       rst_pin_out,
  input wire logic       rst_pin_oe,
  input wire logic       system_reset,
  input wire logic       watchdog_active
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // Accepted register accesses, split by target
  wire logic wd_wr = reg_wr && reg_addr == wdr_pkg::WD_ADDR && !system_reset;
  wire logic rc_wr = reg_wr && reg_addr == wdr_pkg::RC_ADDR && !system_reset;
  wire logic wd_rd = reg_rd && reg_addr == wdr_pkg::WD_ADDR;
  wire logic rc_rd = reg_rd && reg_addr == wdr_pkg::RC_ADDR;

  pin_low_a: assert property (rst_pin_oe |-> !rst_pin_out)
    else $error("reset pin driven high");
  hold_len_a: assert property ($fell(system_reset) |-> $past(system_reset, 12))
    else $error("reset hold shorter than twelve cycles");
  pin_entry_a: assert property (!rst_pin_in && !rst_pin_oe |=> system_reset)
    else $error("pin reset not entered");
  wd_status_a: assert property (wd_rd |=> reg_rdata[4] == $past(watchdog_active)
    && reg_rdata[7:5] == 3'h0 && !reg_rdata[3]) else $error("watchdog read mismatch");
  cause_onehot_a: assert property (rc_rd |=> $onehot(reg_rdata))
    else $error("reset cause not one-hot");
  idle_zero_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  sw_force_a: assert property (rc_wr && reg_wdata[4] && !reg_wdata[1]
    |=> (system_reset && !rst_pin_oe) [*4]) else $error("software reset wrong");
  por_force_a: assert property (rc_wr && reg_wdata[1] |-> ##[1:2] rst_pin_oe)
    else $error("forced power-on did not drive pin");
  reload_on_a: assert property (wd_wr && reg_wdata == wdr_pkg::WD_CMD_RELOAD
    |=> watchdog_active) else $error("reload did not enable");
  lock_keep_a: assert property (wd_wr && reg_wdata == wdr_pkg::WD_CMD_LOCK
    |=> $stable(watchdog_active)) else $error("lockout changed activity");
  reset_active_a: assert property (system_reset |-> watchdog_active)
    else $error("watchdog inactive in reset");

  // Main scenarios reached
  cover property (wd_wr && reg_wdata == wdr_pkg::WD_CMD_DIS2);
  cover property ($rose(rst_pin_oe));
  cover property ($fell(system_reset));
endmodule

bind wdr_reset_ctrl wdr_reset_ctrl_checker #(.POR_HOLD_CYCLES(POR_HOLD_CYCLES)) u_chk (
  .ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .rst_pin_in, .rst_pin_out, .rst_pin_oe, .system_reset, .watchdog_active
);

// ### testbench/test_watchdog_and_reset_sources.sv
// Self-checking bench for the watchdog and reset block
`timescale 1ns/1ps
module test_watchdog_and_reset_sources;
  logic       ref_clk   = 1'b0;
  logic       reset     = 1'b1;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic       cmp_below = 1'b0;
  logic       cnv_in    = 1'b1;
  logic       mcd       = 1'b0;
  logic       tst       = 1'b0;
  logic       ext_pin   = 1'b1;
  logic       clk_en    = 1'b1;
  wire  [7:0] reg_rdata;
  wire        pin_in, pin_out, pin_oe, system_reset, watchdog_active;
  int         fail_count = 0;
  int         num_checks = 0;
  int         n;
  localparam logic [7:0] RC = wdr_pkg::RC_ADDR;
  localparam logic [7:0] WD = wdr_pkg::WD_ADDR;

  // Clock and the resolved reset pin level
  always #5 ref_clk = ~ref_clk;
  assign pin_in = pin_oe ? pin_out : ext_pin;

  wdr_reset_ctrl #(.POR_HOLD_CYCLES(20)) DUT (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .comparator_below(cmp_below), .convert_start_input(cnv_in),
    .missing_clock_detect(mcd), .test_port_reset_cmd(tst), .rst_pin_in(pin_in),
    .rst_pin_out(pin_out), .rst_pin_oe(pin_oe), .system_reset(system_reset),
    .watchdog_active(watchdog_active)
  );

  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    check(what, exp, reg_rdata);
  endtask

  // Counts cycles until system reset (sel 0) or pin drive (sel 1) reaches v
  task automatic wait_lvl(input logic sel, input logic v);
    n = 0;
    while ((sel ? pin_oe : system_reset) !== v && n < 300)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("level reached", 8'h01, {7'h0, n < 300});
  endtask

  // Raises one level source, optionally enabling it late, then checks the cause
  task automatic hit(input int k, input logic [7:0] en);
    @(posedge ref_clk);
    case (k)
      0: ext_pin <= 1'b0;
      2: mcd <= 1'b1;
      5: cmp_below <= 1'b1;
      6: cnv_in <= 1'b0;
      default: tst <= 1'b1;
    endcase
    if (en !== 8'h00)
    begin
      repeat (4) @(posedge ref_clk);
      #1;
      check("disabled source", 8'h00, {7'h0, system_reset});
      wr(RC, en);
    end
    wait_lvl(1'b0, 1'b1);
    check("pin kept", 8'h00, {7'h0, pin_oe});
    repeat (3) @(posedge ref_clk);
    ext_pin   <= 1'b1;
    mcd       <= 1'b0;
    cmp_below <= 1'b0;
    cnv_in    <= 1'b1;
    tst       <= 1'b0;
    wait_lvl(1'b0, 1'b0);
    check("hold length", 8'h01, {7'h0, n >= 12 && n <= 14});
    rd(RC, 8'h01 << k, "reset cause");
  endtask

  // Hang guard
  initial
  begin
    #200000;
    fail_count++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    wait_lvl(1'b0, 1'b0);
    rd(RC, wdr_pkg::RC_CAUSE_POR, "power-on cause");
    rd(WD, 8'h17, "watchdog after reset");
    rd(8'h00, 8'h00, "unmapped read");
    wr(WD, 8'h00);
    rd(WD, 8'h10, "interval zero");
    wr(WD, 8'h85);
    rd(WD, 8'h10, "interval kept");
    wr(WD, wdr_pkg::WD_CMD_RELOAD);
    // Frozen for longer than the limit: the count must not move meanwhile
    clk_en <= 1'b0;
    repeat (100) @(posedge ref_clk);
    clk_en <= 1'b1;
    wait_lvl(1'b0, 1'b1);
    check("timeout", 8'h01, {7'h0, n >= 62 && n <= 66});
    wait_lvl(1'b0, 1'b0);
    rd(RC, 8'h08, "watchdog cause");
    rd(WD, 8'h17, "restart");
    wr(WD, wdr_pkg::WD_CMD_DIS1);
    repeat (3) @(posedge ref_clk);
    wr(WD, wdr_pkg::WD_CMD_DIS2);
    rd(WD, 8'h17, "late disable");
    wr(WD, wdr_pkg::WD_CMD_DIS1);
    wr(WD, 8'h81);
    wr(WD, wdr_pkg::WD_CMD_DIS2);
    rd(WD, 8'h17, "cancelled disable");
    wr(WD, wdr_pkg::WD_CMD_DIS1);
    repeat (2) @(posedge ref_clk);
    wr(WD, wdr_pkg::WD_CMD_DIS2);
    rd(WD, 8'h07, "disabled");
    check("active port", 8'h00, {7'h0, watchdog_active});
    wr(WD, wdr_pkg::WD_CMD_LOCK);
    rd(WD, 8'h07, "lock no enable");
    wr(WD, wdr_pkg::WD_CMD_RELOAD);
    wr(WD, wdr_pkg::WD_CMD_DIS1);
    wr(WD, wdr_pkg::WD_CMD_DIS2);
    rd(WD, 8'h17, "locked");
    wr(RC, 8'h00);
    repeat (3) @(posedge ref_clk);
    check("zero write", 8'h00, {7'h0, system_reset});
    wr(RC, 8'h10);
    wait_lvl(1'b0, 1'b1);
    check("sw pin kept", 8'h00, {7'h0, pin_oe});
    wait_lvl(1'b0, 1'b0);
    rd(RC, 8'h10, "software cause");
    wr(WD, wdr_pkg::WD_CMD_DIS1);
    wr(WD, wdr_pkg::WD_CMD_DIS2);
    rd(WD, 8'h07, "lock cleared");
    wr(RC, 8'h02);
    wait_lvl(1'b1, 1'b1);
    check("pin low", 8'h00, {7'h0, pin_in});
    wait_lvl(1'b1, 1'b0);
    check("pin drive length", 8'h01, {7'h0, n >= 19 && n <= 21});
    wait_lvl(1'b0, 1'b0);
    rd(RC, 8'h02, "forced power-on");
    hit(0, 8'h00);
    hit(2, 8'h00);
    hit(5, 8'h20);
    hit(6, 8'h40);
    hit(7, 8'h00);
    report_and_stop();
  end
endmodule
